// [rtl/ivec_defines.svh]
// Register indices, field positions, reset values and vector constants
`ifndef IVEC_DEFINES_SVH
`define IVEC_DEFINES_SVH

`define AXI_AW        6
`define IDX_IE1       4'h0
`define IDX_IE2       4'h1
`define IDX_FLAG1     4'h2
`define IDX_FLAG2     4'h3
`define IDX_ME2       4'h5
`define IDX_STAT      4'h8

`define F1_WDT        0
`define F1_OSC        1
`define F1_DIO0       2
`define F1_DIO1       3
`define F1_NMI        4
`define FLAG1_MASK    8'h1f
`define FLAG1_RST     8'h02
`define IE1_MASK      8'h0f

`define F2_RX         0
`define F2_TX         1
`define F2_BT         7
`define FLAG2_MASK    8'h83
`define FLAG2_RST     8'h02
`define IE2_MASK      8'h83

`define ME2_RXE       0
`define ME2_TXE       1
`define ME2_MASK      8'h03
`define ME2_RST       8'h00

`define VEC_BASE      16'hffe0
`define PRIO_RESET    4'hf
`define PRIO_NMI      4'he
`define PRIO_DIO0     4'hd
`define PRIO_DIO1     4'hc
`define PRIO_WDT      4'ha
`define PRIO_CC0      4'h9
`define PRIO_TMR      4'h8
`define PRIO_RX       4'h7
`define PRIO_TX       4'h6
`define PRIO_TP       4'h4
`define PRIO_P2       4'h3
`define PRIO_P1       4'h2
`define PRIO_BT       4'h1
`define PRIO_P0       4'h0

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// [rtl/ivec_pkg.sv]
// Types shared by the interrupt vector and flag block
package ivec_pkg;

  typedef struct packed {
    logic       wdtOverflow;
    logic       wdtKeyViolation;
    logic       wdtResetMode;
    logic       oscFault;
    logic       dio0Event;
    logic       dio1Event;
    logic       rxEvent;
    logic       txEvent;
    logic       basicTimerEvent;
    logic       captureCompare0Flag;
    logic       mainTimerFlag;
    logic       timerPortReq;
    logic [5:0] port0UpperFlags;
    logic [7:0] port1PinFlags;
    logic [7:0] port2PinFlags;
  } periph_events_t;

  typedef struct packed {
    logic [3:0]  prio;
    logic [15:0] addr;
    logic [15:0] handler;
  } vector_out_t;

endpackage

// [rtl/interrupt_vector_sfr.sv]
// Interrupt flag collection, fixed-priority vectoring and special-function registers
//
// Overview of operation
// RULE1: Start address and all vectors are sixteen words from 0FFE0h to 0FFFFh.
// RULE2: Each vector word is a 16-bit handler address handed to the core.
// RULE3: Power-up, pin reset and watchdog reset use 0FFFEh at priority 15.
// RULE4: Fixed vectors for watchdog interval, serial, timer/port, basic timer, dedicated I/O 0.
// RULE5: Hardware sets flags; software polls, enables and clears them.
// RULE6: Falling level on reset/NMI pin sets NMI flag, vector 0FFFCh priority 14.
// RULE7: Oscillator fault sets its flag, shares 0FFFCh, maskable by its enable.
// RULE8: Watchdog overflow or key violation sets the watchdog flag.
// RULE9: Only power-on or pin reset clears the watchdog flag; here acceptance of its vector or a software write also clears it.
// RULE10: Dedicated I/O 1 flag also serves timer receive, vector 0FFF8h priority 12.
// RULE11: Port 2 eight flags form one request, 0FFE6h priority 3.
// RULE12: Port 1 eight flags form one request, 0FFE4h priority 2.
// RULE13: Port 0 flags 2 to 7 form one request, 0FFE0h priority 0.
// RULE14: Timer capture/compare, main timer, timer/port flags stay in their modules.
// RULE15: Unassigned special-function bits hold no storage and read zero.
// RULE16: Flag register one at 02h, flag register two at 03h.
// RULE17: Module enable two at 05h holds serial tx/rx enables, reset zero.
// RULE18: Any interrupt wakes the core; return restores the prior mode.
// RULE19: Highest fixed priority pending request is offered first; others stay pending.
// RULE20: Maskable requests need their own enable and the global enable.
`include "ivec_defines.svh"

module interrupt_vector_sfr
  import ivec_pkg::*;
#(
  parameter logic [255:0] VECTOR_WORDS = 256'h0
)(
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire logic                 rstNmiPin,
  input  wire periph_events_t       periph,
  input  wire logic                 globalIrqEnable,
  input  wire logic                 irqAck,
  input  wire logic                 returnFromInterrupt,
  input  wire logic [3:0]           cpuMode,
  output logic                      irqReq,
  output vector_out_t               vecOut,
  output logic                      wakeReq,
  output logic [3:0]                modeRestore,
  output logic                      modeRestoreValid,
  output logic                      serialTxEnable,
  output logic                      serialRxEnable,
  input  wire logic [`AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [`AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  logic [1:0]         rstSync;
  logic               rstN;
  logic [2:0]         pinSync;
  logic               pinStableReg;
  logic               nmiEdgeReg;
  logic               awHeldReg;
  logic [3:0]         awIdxReg;
  logic               wHeldReg;
  logic [7:0]         wDataReg;
  logic               wLaneReg;
  logic               doWrite;
  logic               bvalidReg;
  logic [1:0]         brespReg;
  logic               rvalidReg;
  logic [31:0]        rdataReg;
  logic [1:0]         rrespReg;
  logic [7:0]         flag1Reg;
  logic [7:0]         flag1Next;
  logic [7:0]         flag2Reg;
  logic [7:0]         flag2Next;
  logic [7:0]         ie1Reg;
  logic [7:0]         ie2Reg;
  logic [7:0]         me2Reg;
  logic               startupReg;
  logic               wdtResetPendReg;
  logic [15:0]        reqs;
  logic               validReg;
  logic [3:0]         prioReg;
  logic [15:0]        addrReg;
  logic [15:0]        handlerReg;
  logic               ackBlankReg;
  logic               accept;
  logic [3:0]         savedModeReg;
  logic [3:0]         modeRestoreReg;
  logic               restoreValidReg;
  logic               wdtSet;
  logic [15:0]        vecRom [16];

  function automatic logic [3:0] topPrio(input logic [15:0] r);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (r[i]) begin
        p = 4'(i);
      end
    end
    return p;
  endfunction

  function automatic logic [3:0] regIdx(input logic [`AXI_AW-1:0] a);
    return a[`AXI_AW-1:2];
  endfunction

  function automatic logic isMapped(input logic [3:0] idx);
    return idx == `IDX_IE1 || idx == `IDX_IE2 || idx == `IDX_FLAG1 ||
           idx == `IDX_FLAG2 || idx == `IDX_ME2 || idx == `IDX_STAT;
  endfunction

  // Reset release through two stages
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // Vector words sit at 0FFE0h + 2 * priority
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      vecRom[i] = VECTOR_WORDS[i*16 +: 16]; // RULE1
    end
  end

  // Pin filter: a new level counts once stages two and three agree
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pinSync      <= 3'h7;
      pinStableReg <= 1'b1;
      nmiEdgeReg   <= 1'b0;
    end else begin
      pinSync <= {pinSync[1:0], rstNmiPin};
      if (pinSync[1] == pinSync[2]) begin
        pinStableReg <= pinSync[2];
      end
      nmiEdgeReg <= pinStableReg && (pinSync[1] == pinSync[2]) && !pinSync[2]; // RULE6
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !awHeldReg;
  assign s_axi_wready  = !wHeldReg;
  assign doWrite       = awHeldReg && wHeldReg && !bvalidReg;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      awHeldReg <= 1'b0;
      awIdxReg  <= 4'h0;
      wHeldReg  <= 1'b0;
      wDataReg  <= 8'h00;
      wLaneReg  <= 1'b0;
      bvalidReg <= 1'b0;
      brespReg  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeldReg) begin
        awHeldReg <= 1'b1;
        awIdxReg  <= regIdx(s_axi_awaddr);
      end else if (doWrite) begin
        awHeldReg <= 1'b0;
      end
      if (s_axi_wvalid && !wHeldReg) begin
        wHeldReg <= 1'b1;
        wDataReg <= s_axi_wdata[7:0];
        wLaneReg <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeldReg <= 1'b0;
      end
      if (doWrite) begin
        bvalidReg <= 1'b1;
        brespReg  <= isMapped(awIdxReg) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalidReg <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalidReg;
  assign s_axi_bresp  = brespReg;

  function automatic logic wrHit(input logic [3:0] idx);
    return doWrite && wLaneReg && awIdxReg == idx;
  endfunction

  // AXI4-Lite read; unassigned bits come back zero
  assign s_axi_arready = !rvalidReg;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rvalidReg <= 1'b0;
      rdataReg  <= 32'h0;
      rrespReg  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !rvalidReg) begin
      rvalidReg <= 1'b1;
      rrespReg  <= isMapped(regIdx(s_axi_araddr)) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (regIdx(s_axi_araddr))
        `IDX_IE1:   rdataReg <= {24'h0, ie1Reg};
        `IDX_IE2:   rdataReg <= {24'h0, ie2Reg};
        `IDX_FLAG1: rdataReg <= {24'h0, flag1Reg}; // RULE16
        `IDX_FLAG2: rdataReg <= {24'h0, flag2Reg}; // RULE16
        `IDX_ME2:   rdataReg <= {24'h0, me2Reg};
        `IDX_STAT:  rdataReg <= {11'h0, validReg, prioReg, addrReg};
        default:    rdataReg <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      rvalidReg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalidReg;
  assign s_axi_rdata  = rdataReg;
  assign s_axi_rresp  = rrespReg;

  assign accept = irqReq && irqAck;
  assign wdtSet = periph.wdtOverflow || periph.wdtKeyViolation;

  // Flags: a hardware set beats a software write or an acceptance clear
  always_comb begin
    flag1Next = wrHit(`IDX_FLAG1) ? wDataReg : flag1Reg; // RULE5
    if (accept && prioReg == `PRIO_WDT) begin
      flag1Next[`F1_WDT] = 1'b0;
    end
    flag1Next[`F1_WDT]  = flag1Next[`F1_WDT] | wdtSet; // RULE8
    flag1Next[`F1_OSC]  = flag1Next[`F1_OSC] | periph.oscFault; // RULE7
    flag1Next[`F1_DIO0] = flag1Next[`F1_DIO0] | periph.dio0Event;
    flag1Next[`F1_DIO1] = flag1Next[`F1_DIO1] | periph.dio1Event; // RULE10
    flag1Next[`F1_NMI]  = flag1Next[`F1_NMI] | nmiEdgeReg; // RULE6
    flag1Next = flag1Next & `FLAG1_MASK; // RULE15
  end

  always_comb begin
    flag2Next = wrHit(`IDX_FLAG2) ? wDataReg : flag2Reg; // RULE5
    if (accept && prioReg == `PRIO_BT) begin
      flag2Next[`F2_BT] = 1'b0;
    end
    flag2Next[`F2_RX] = flag2Next[`F2_RX] | (periph.rxEvent && me2Reg[`ME2_RXE]);
    flag2Next[`F2_TX] = flag2Next[`F2_TX] | (periph.txEvent && me2Reg[`ME2_TXE]);
    flag2Next[`F2_BT] = flag2Next[`F2_BT] | periph.basicTimerEvent;
    flag2Next = flag2Next & `FLAG2_MASK; // RULE15
  end

  // This reset path, a software write and watchdog vector acceptance clear the watchdog flag
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      flag1Reg <= `FLAG1_RST; // RULE9
      flag2Reg <= `FLAG2_RST;
    end else begin
      flag1Reg <= flag1Next;
      flag2Reg <= flag2Next;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ie1Reg <= 8'h00;
      ie2Reg <= 8'h00;
      me2Reg <= `ME2_RST; // RULE17
    end else begin
      if (wrHit(`IDX_IE1)) begin
        ie1Reg <= wDataReg & `IE1_MASK;
      end
      if (wrHit(`IDX_IE2)) begin
        ie2Reg <= wDataReg & `IE2_MASK;
      end
      if (wrHit(`IDX_ME2)) begin
        me2Reg <= wDataReg & `ME2_MASK; // RULE17
      end
    end
  end
  assign serialTxEnable = me2Reg[`ME2_TXE]; // RULE17
  assign serialRxEnable = me2Reg[`ME2_RXE]; // RULE17

  // Start-up and watchdog reset requests hold until the core takes the reset vector
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      startupReg      <= 1'b1; // RULE3
      wdtResetPendReg <= 1'b0;
    end else begin
      if (accept && prioReg == `PRIO_RESET) begin
        startupReg <= 1'b0;
      end
      if (wdtSet && periph.wdtResetMode) begin
        wdtResetPendReg <= 1'b1; // RULE3
      end else if (accept && prioReg == `PRIO_RESET) begin
        wdtResetPendReg <= 1'b0;
      end
    end
  end

  // Request map; module-held timer flags arrive already enabled
  always_comb begin
    reqs = 16'h0;
    reqs[`PRIO_RESET] = startupReg || wdtResetPendReg; // RULE3
    reqs[`PRIO_NMI]   = flag1Reg[`F1_NMI] || (flag1Reg[`F1_OSC] && ie1Reg[`F1_OSC]); // RULE6 RULE7
    reqs[`PRIO_DIO0]  = globalIrqEnable && flag1Reg[`F1_DIO0] && ie1Reg[`F1_DIO0]; // RULE4 RULE20
    reqs[`PRIO_DIO1]  = globalIrqEnable && flag1Reg[`F1_DIO1] && ie1Reg[`F1_DIO1]; // RULE10 RULE20
    reqs[`PRIO_WDT]   = globalIrqEnable && flag1Reg[`F1_WDT] && ie1Reg[`F1_WDT] &&
                        !periph.wdtResetMode; // RULE4 RULE20
    reqs[`PRIO_CC0]   = globalIrqEnable && periph.captureCompare0Flag; // RULE14
    reqs[`PRIO_TMR]   = globalIrqEnable && periph.mainTimerFlag; // RULE14
    reqs[`PRIO_RX]    = globalIrqEnable && flag2Reg[`F2_RX] && ie2Reg[`F2_RX]; // RULE4 RULE20
    reqs[`PRIO_TX]    = globalIrqEnable && flag2Reg[`F2_TX] && ie2Reg[`F2_TX]; // RULE4 RULE20
    reqs[`PRIO_TP]    = globalIrqEnable && periph.timerPortReq; // RULE4 RULE14
    reqs[`PRIO_P2]    = globalIrqEnable && (|periph.port2PinFlags); // RULE11
    reqs[`PRIO_P1]    = globalIrqEnable && (|periph.port1PinFlags); // RULE12
    reqs[`PRIO_BT]    = globalIrqEnable && flag2Reg[`F2_BT] && ie2Reg[`F2_BT]; // RULE4 RULE20
    reqs[`PRIO_P0]    = globalIrqEnable && (|periph.port0UpperFlags); // RULE13
  end

  // Pending vector registered every cycle; one blank cycle after acceptance hides stale state
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      validReg    <= 1'b0;
      prioReg     <= 4'h0;
      addrReg     <= `VEC_BASE;
      handlerReg  <= 16'h0;
      ackBlankReg <= 1'b0;
    end else begin
      validReg    <= |reqs;
      prioReg     <= topPrio(reqs); // RULE19
      addrReg     <= `VEC_BASE + {11'h0, topPrio(reqs), 1'b0}; // RULE1
      handlerReg  <= vecRom[topPrio(reqs)]; // RULE2
      ackBlankReg <= accept;
    end
  end
  assign irqReq  = validReg && !ackBlankReg;
  assign wakeReq = irqReq; // RULE18
  assign vecOut  = '{prio: prioReg, addr: addrReg, handler: handlerReg};

  // Single saved mode: nested handlers must rely on the core's own stack
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      savedModeReg    <= 4'h0;
      modeRestoreReg  <= 4'h0;
      restoreValidReg <= 1'b0;
    end else begin
      if (accept) begin
        savedModeReg <= cpuMode; // RULE18
      end
      restoreValidReg <= returnFromInterrupt;
      if (returnFromInterrupt) begin
        modeRestoreReg <= savedModeReg; // RULE18
      end
    end
  end
  assign modeRestore      = modeRestoreReg;
  assign modeRestoreValid = restoreValidReg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  sequence s_taken;
    irqReq && irqAck;
  endsequence

  sequence s_return;
    returnFromInterrupt ##1 modeRestoreValid;
  endsequence

  a_vector_address: assert property (validReg |-> addrReg == `VEC_BASE + {11'h0, prioReg, 1'b0}) // RULE1
    else $error("vector address does not match priority");
  a_handler_word: assert property (validReg |-> handlerReg == vecRom[prioReg]) // RULE2
    else $error("handler word not taken from vector table");
  a_reset_first: assert property ($rose(rstN) ##1 1'b1 |-> validReg && prioReg == `PRIO_RESET) // RULE3
    else $error("start-up did not request the reset vector");
  a_nmi_sets: assert property (nmiEdgeReg |=> flag1Reg[`F1_NMI] ##1 validReg && prioReg >= `PRIO_NMI) // RULE6
    else $error("pin event did not raise the nmi vector");
  a_osc_sets: assert property (periph.oscFault |=> flag1Reg[`F1_OSC]) // RULE7
    else $error("oscillator fault flag not set");
  a_wdt_sets: assert property ((periph.wdtOverflow || periph.wdtKeyViolation) |=> flag1Reg[`F1_WDT]) // RULE8
    else $error("watchdog event did not set its flag");
  a_wdt_holds: assert property (flag1Reg[`F1_WDT] && !accept && // RULE9
                                !(doWrite && wLaneReg && awIdxReg == `IDX_FLAG1) |=> flag1Reg[`F1_WDT])
    else $error("watchdog flag lost without a clear");
  a_port2_source: assert property (validReg && prioReg == `PRIO_P2 |-> $past(|periph.port2PinFlags)) // RULE11
    else $error("port two vector without a pin flag");
  a_port1_source: assert property (validReg && prioReg == `PRIO_P1 |-> $past(|periph.port1PinFlags)) // RULE12
    else $error("port one vector without a pin flag");
  a_port0_source: assert property (validReg && prioReg == `PRIO_P0 |-> $past(|periph.port0UpperFlags)) // RULE13
    else $error("port zero vector without a pin flag");
  a_serial_reset: assert property ($rose(rstN) |-> !serialTxEnable && !serialRxEnable) // RULE17
    else $error("serial enables not cleared by reset");
  a_mode_saved: assert property (s_taken |=> savedModeReg == $past(cpuMode)) // RULE18
    else $error("mode not saved on acceptance");
  a_wake_restore: assert property (s_return |-> modeRestore == $past(savedModeReg)) // RULE18
    else $error("return did not restore the saved mode");
  a_highest_wins: assert property (validReg |-> ($past(reqs) >> prioReg) == 16'h0001) // RULE19
    else $error("a higher request was passed over");
  a_global_mask: assert property (validReg && !$past(globalIrqEnable) |-> prioReg >= `PRIO_NMI) // RULE20
    else $error("maskable request taken with global enable low");

endmodule

// [tb/core_model.sv]
// Processor core stand-in that accepts offered vectors after a set wait
module core_model
  import ivec_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        irqReq,
  input  wire vector_out_t vecOut,
  input  wire logic        ackEn,
  input  wire logic [3:0]  ackDelay,
  output logic             irqAck,
  output vector_out_t      taken,
  output int unsigned      acceptCount
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] waitCnt;

  initial begin
    irqAck = 1'b0;
    taken = '0;
    acceptCount = 0;
    waitCnt = 4'h0;
  end

  // Ack counts only while still offered; the word taken is the next fetch address
  always @(posedge mclk) begin
    if (irqAck) begin
      irqAck <= 1'b0;
      waitCnt <= 4'h0;
      if (irqReq) begin
        taken <= vecOut;
        acceptCount <= acceptCount + 1;
      end
    end else if (ackEn && irqReq) begin
      if (waitCnt >= ackDelay)
        irqAck <= 1'b1;
      else
        waitCnt <= waitCnt + 4'h1;
    end else begin
      waitCnt <= 4'h0;
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the interrupt vector and flag block
`include "ivec_defines.svh"
module tb_top
  import ivec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  function automatic logic [255:0] vec_words();
    logic [255:0] v;
    for (int i = 0; i < 16; i++)
      v[16*i +: 16] = 16'hc050 | (16'(i) << 8) | 16'(i);
    return v;
  endfunction

  localparam logic [255:0] VW = vec_words();
  localparam logic [5:0] A_IE1 = {`IDX_IE1, 2'b00};
  localparam logic [5:0] A_IE2 = {`IDX_IE2, 2'b00};
  localparam logic [5:0] A_FL1 = {`IDX_FLAG1, 2'b00};
  localparam logic [5:0] A_FL2 = {`IDX_FLAG2, 2'b00};
  localparam logic [5:0] A_ME2 = {`IDX_ME2, 2'b00};

  logic           mclk, nrst, rstNmiPin, globalIrqEnable, returnFromInterrupt, irqAck, irqReq, wakeReq;
  logic           modeRestoreValid, serialTxEnable, serialRxEnable, ackEn;
  logic [3:0]     cpuMode, modeRestore, ackDelay, wstrb;
  logic [5:0]     awaddr, araddr;
  logic [31:0]    wdata, rdata;
  logic [1:0]     bresp, rresp;
  logic           awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  periph_events_t periph;
  vector_out_t    vecOut, taken;
  int unsigned    acceptCount;
  int             mismatches, totalChecks;

  interrupt_vector_sfr #(.VECTOR_WORDS(VW)) dut_u (
    .mclk(mclk), .nrst(nrst), .rstNmiPin(rstNmiPin), .periph(periph), .globalIrqEnable(globalIrqEnable),
    .irqAck(irqAck), .returnFromInterrupt(returnFromInterrupt), .cpuMode(cpuMode), .irqReq(irqReq),
    .vecOut(vecOut), .wakeReq(wakeReq), .modeRestore(modeRestore), .modeRestoreValid(modeRestoreValid),
    .serialTxEnable(serialTxEnable), .serialRxEnable(serialRxEnable),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  core_model core_u (.mclk(mclk), .irqReq(irqReq), .vecOut(vecOut), .ackEn(ackEn), .ackDelay(ackDelay),
    .irqAck(irqAck), .taken(taken), .acceptCount(acceptCount));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Slave latency is not assumed; only the watchdog ends a wait
  task automatic axi_write(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check({30'h0, awvalid, wvalid}, 32'h0, "write channels taken");
    check({30'h0, bresp}, {30'h0, er}, "write response");
  endtask

  task automatic axi_read(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    check(rdata, {24'h0, e}, "read data");
    check({30'h0, rresp}, {30'h0, er}, "read response");
  endtask

  // Vector output lags a flag change by a cycle, so let it settle first
  task automatic check_vec(input logic [3:0] p);
    int n;
    repeat (3) @(posedge mclk);
    for (n = 0; n < 20 && irqReq !== 1'b1; n++) @(posedge mclk);
    check({28'h0, vecOut.prio}, {28'h0, p}, "priority");
    check({16'h0, vecOut.addr}, {16'h0, 16'hffe0 + {11'h0, p, 1'b0}}, "vector address");
    check({16'h0, vecOut.handler}, {16'h0, VW[16*p +: 16]}, "handler");
    check({31'h0, wakeReq}, 32'h1, "wake");
  endtask

  task automatic wait_accept(input logic [3:0] p);
    int unsigned c;
    int n;
    c = acceptCount;
    ackEn <= 1'b1;
    for (n = 0; n < 40 && acceptCount == c; n++) @(posedge mclk);
    ackEn <= 1'b0;
    check(acceptCount - c, 32'h1, "accept count");
    check({28'h0, taken.prio}, {28'h0, p}, "accepted priority");
    check({16'h0, taken.handler}, {16'h0, VW[16*p +: 16]}, "accepted handler");
  endtask

  task automatic test_reset();
    wait_accept(4'hf);
    check({16'h0, taken.addr}, 32'h0000fffe, "start address");
    axi_read(A_FL1, 8'h02, `RESP_OKAY);
    axi_read(A_FL2, 8'h02, `RESP_OKAY);
    axi_read(A_ME2, 8'h00, `RESP_OKAY);
    periph.rxEvent <= 1'b1;
    @(posedge mclk);
    periph.rxEvent <= 1'b0;
    axi_read(A_FL2, 8'h02, `RESP_OKAY);
    axi_write(A_ME2, 8'hff, `RESP_OKAY);
    axi_read(A_ME2, 8'h03, `RESP_OKAY);
    check({30'h0, serialTxEnable, serialRxEnable}, 32'h3, "serial enables");
    axi_read(6'h18, 8'h00, `RESP_SLVERR);
  endtask

  task automatic test_priority();
    globalIrqEnable <= 1'b1;
    axi_write(A_IE1, 8'h0c, `RESP_OKAY);
    axi_write(A_IE2, 8'h83, `RESP_OKAY);
    periph.dio0Event <= 1'b1;
    periph.dio1Event <= 1'b1;
    periph.rxEvent <= 1'b1;
    periph.basicTimerEvent <= 1'b1;
    @(posedge mclk);
    periph <= '0;
    check_vec(4'hd);
    axi_write(A_FL1, 8'h0a, `RESP_OKAY);
    check_vec(4'hc);
    axi_write(A_FL1, 8'h02, `RESP_OKAY);
    check_vec(4'h7);
    axi_write(A_FL2, 8'h82, `RESP_OKAY);
    check_vec(4'h6);
    axi_write(A_FL2, 8'h80, `RESP_OKAY);
    check_vec(4'h1);
    ackDelay <= 4'h3;
    wait_accept(4'h1);
    axi_read(A_FL2, 8'h00, `RESP_OKAY);
  endtask

  task automatic test_mask();
    logic [3:0] pr [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9};
    globalIrqEnable <= 1'b0;
    periph.port0UpperFlags <= 6'h20;
    repeat (4) @(posedge mclk);
    check({31'h0, irqReq}, 32'h0, "masked request");
    globalIrqEnable <= 1'b1;
    check_vec(pr[0]);
    for (int k = 1; k < 6; k++) begin
      case (k)
        1: periph.port1PinFlags <= 8'h01;
        2: periph.port2PinFlags <= 8'h80;
        3: periph.timerPortReq <= 1'b1;
        4: periph.mainTimerFlag <= 1'b1;
        default: periph.captureCompare0Flag <= 1'b1;
      endcase
      check_vec(pr[k]);
    end
    periph <= '0;
    globalIrqEnable <= 1'b0;
    axi_write(A_IE1, 8'h0e, `RESP_OKAY);
    check_vec(4'he);
    axi_write(A_FL1, 8'h00, `RESP_OKAY);
    repeat (3) @(posedge mclk);
    check({31'h0, irqReq}, 32'h0, "flag cleared");
  endtask

  task automatic test_nmi();
    rstNmiPin <= 1'b0;
    repeat (6) @(posedge mclk);
    rstNmiPin <= 1'b1;
    check_vec(4'he);
    axi_read(A_FL1, 8'h10, `RESP_OKAY);
    axi_write(A_FL1, 8'h00, `RESP_OKAY);
  endtask

  task automatic test_watchdog();
    globalIrqEnable <= 1'b1;
    cpuMode <= 4'h9;
    axi_write(A_IE1, 8'h01, `RESP_OKAY);
    periph.wdtOverflow <= 1'b1;
    @(posedge mclk);
    periph.wdtOverflow <= 1'b0;
    check_vec(4'ha);
    wait_accept(4'ha);
    axi_read(A_FL1, 8'h00, `RESP_OKAY);
    returnFromInterrupt <= 1'b1;
    @(posedge mclk);
    returnFromInterrupt <= 1'b0;
    @(posedge mclk);
    check({27'h0, modeRestoreValid, modeRestore}, {27'h0, 1'b1, 4'h9}, "mode restore");
    axi_write(A_IE1, 8'h00, `RESP_OKAY);
    periph.wdtResetMode <= 1'b1;
    periph.wdtKeyViolation <= 1'b1;
    @(posedge mclk);
    periph.wdtKeyViolation <= 1'b0;
    check_vec(4'hf);
    wait_accept(4'hf);
    axi_read(A_FL1, 8'h01, `RESP_OKAY);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    periph.wdtResetMode <= 1'b0;
    wait_accept(4'hf);
    axi_read(A_FL1, 8'h02, `RESP_OKAY);
    axi_read(A_ME2, 8'h00, `RESP_OKAY);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    nrst = 1'b0;
    rstNmiPin = 1'b1;
    periph = '0;
    globalIrqEnable = 1'b0;
    returnFromInterrupt = 1'b0;
    cpuMode = 4'h0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, arvalid, ackEn} = 4'h0;
    {bready, rready} = 2'b11;
    wstrb = 4'hf;
    ackDelay = 4'h0;
    mismatches = 0;
    totalChecks = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (5) @(posedge mclk);
    test_reset();
    $display("test_reset finished");
    test_priority();
    $display("test_priority finished");
    test_mask();
    $display("test_mask finished");
    test_nmi();
    $display("test_nmi finished");
    test_watchdog();
    $display("test_watchdog finished");
    end_sim();
  end
endmodule
